//--- common/spm_pkg.sv
// register map, field layout and timing constants of the spi master port
package spm_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CLKGEN = 12'h004;
    localparam logic [11:0] ADDR_TXDATA = 12'h008;
    localparam logic [11:0] ADDR_RXDATA = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // control register bit positions
    localparam int CTRL_LSB = 0;
    localparam int CTRL_TXPH = 1;
    localparam int CTRL_RXPH = 2;
    localparam int CTRL_CPOL = 3;
    localparam int CTRL_HALF = 4;
    localparam int CTRL_HTX = 5;
    localparam int CTRL_CS = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h00;

    // status register bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_RXFULL = 1;

    // serial clock generator: half period is (setting + 1) oscillator cycles
    localparam int DIV_W = 11;
    localparam logic [10:0] DIV_RST = 11'h0ff;
    localparam real OSC_MHZ = 48.0;
    localparam real TP_MIN_NS = 20.8;
    localparam real TP_MAX_NS = 62492.25;
    localparam int HALF_MIN = (int'($ceil(TP_MIN_NS * OSC_MHZ / 2000.0)) < 1) ? 1 :
        int'($ceil(TP_MIN_NS * OSC_MHZ / 2000.0));
    localparam int HALF_MAX = int'($floor(TP_MAX_NS * OSC_MHZ / 2000.0));
    localparam logic [10:0] DIV_MIN = 11'(HALF_MIN - 1);
    localparam logic [10:0] DIV_MAX = 11'(HALF_MAX - 1);

    localparam logic [4:0] EDGES = 5'h10;

    typedef enum {L_IDLE, L_RUN, L_TAIL} spm_lstate_t;
endpackage

//--- rtl/spm_top.sv
// spi master port: apb register file, clock generator and shift engine
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module spm_top
    import spm_pkg::*;
(
    input wire logic CLK_I, // register bus clock, 20 mhz
    input wire logic RST_I, // asynchronous reset, active high
    input wire logic LINK_CLK_I, // oscillator clock of the serial engine
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction, high for write
    input wire logic [11:0] PADDR_I, // apb byte address
    input wire logic [31:0] PWDATA_I, // apb write data
    output logic [31:0] PRDATA_O, // apb read data
    output logic PREADY_O, // apb ready
    output logic PSLVERR_O, // apb error on unmapped address
    output logic SCLK_O, // serial shift clock
    output logic CS_N_O, // chip select, active low
    output logic DOUT_O, // serial data out, or the shared line in half duplex
    output logic DOUT_OE_N_O, // data line enable, low while driving
    input wire logic DOUT_I, // level on the shared line in half duplex
    input wire logic DIN_I // serial data in, full duplex
);
    function automatic logic bit_at(input logic [7:0] d, input logic [2:0] p, input logic lsb);
        bit_at = lsb ? d[p] : d[3'h7 - p];
    endfunction

    // ---------------- register side ----------------
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [DIV_W-1:0] div_r;
    logic [7:0] tx_r;
    logic [7:0] rxd_r;
    logic busy_r;
    logic rxfull_r;
    logic cs_n_r;
    logic start_tgl_r;
    logic dn_s1_r;
    logic dn_s2_r;
    logic dn_s3_r;
    // link-side results, declared here because the register side reads them
    logic [7:0] rx_byte_r;
    logic done_tgl_r;

    wire setup = PSEL_I & ~PENABLE_I;
    wire access = PSEL_I & PENABLE_I & pready_r;
    wire sel_ctrl = PADDR_I == ADDR_CTRL;
    wire sel_clk = PADDR_I == ADDR_CLKGEN;
    wire sel_tx = PADDR_I == ADDR_TXDATA;
    wire sel_rx = PADDR_I == ADDR_RXDATA;
    wire sel_st = PADDR_I == ADDR_STATUS;
    wire mapped = sel_ctrl | sel_clk | sel_tx | sel_rx | sel_st;
    wire wr_ctrl = access & PWRITE_I & sel_ctrl;
    wire wr_clk = access & PWRITE_I & sel_clk & ~busy_r;
    wire wr_tx = access & PWRITE_I & sel_tx & ~busy_r;
    wire rd_rx = access & ~PWRITE_I & sel_rx;
    wire done_evt = dn_s2_r ^ dn_s3_r;

    // clamp keeps the period inside the range the generator may produce
    wire [DIV_W-1:0] wdiv = PWDATA_I[DIV_W-1:0];
    wire [DIV_W-1:0] div_nxt = (wdiv > DIV_MAX) ? DIV_MAX :
        (wdiv < DIV_MIN) ? DIV_MIN : wdiv;
    // mode bits are frozen while busy; chip select stays free for software
    wire [CTRL_W-1:0] ctrl_nxt = busy_r ?
        {PWDATA_I[CTRL_CS], ctrl_r[CTRL_CS-1:0]} : PWDATA_I[CTRL_W-1:0];
    wire [31:0] rdmux = sel_ctrl ? {25'h0, ctrl_r} :
        sel_clk ? {21'h0, div_r} :
        sel_tx ? {24'h0, tx_r} :
        sel_rx ? {24'h0, rxd_r} :
        sel_st ? {30'h0, rxfull_r, busy_r} : 32'h0;
    wire rxfull_nxt = done_evt | (rxfull_r & ~rd_rx);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= setup ? rdmux : prdata_r;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_r <= CTRL_RST;
            div_r <= DIV_RST;
            tx_r <= 8'h00;
            cs_n_r <= 1'b1;
        end else begin
            ctrl_r <= wr_ctrl ? ctrl_nxt : ctrl_r;
            div_r <= wr_clk ? div_nxt : div_r;
            tx_r <= wr_tx ? PWDATA_I[7:0] : tx_r;
            cs_n_r <= wr_ctrl ? ~PWDATA_I[CTRL_CS] : cs_n_r;
        end
    end

    // done event beats the clear from a read in the same cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_r <= 1'b0;
            rxfull_r <= 1'b0;
            rxd_r <= 8'h00;
            start_tgl_r <= 1'b0;
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
            dn_s3_r <= 1'b0;
        end else begin
            busy_r <= wr_tx | (busy_r & ~done_evt);
            rxfull_r <= rxfull_nxt;
            rxd_r <= done_evt ? rx_byte_r : rxd_r;
            start_tgl_r <= start_tgl_r ^ wr_tx;
            dn_s1_r <= done_tgl_r;
            dn_s2_r <= dn_s1_r;
            dn_s3_r <= dn_s2_r;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign CS_N_O = cs_n_r;

    // ---------------- link side ----------------
    // config and tx byte are stable from the start toggle until done returns
    logic lrst_s1_r;
    logic lrst_r;
    logic st_s1_r;
    logic st_s2_r;
    logic st_s3_r;
    logic din_s1_r;
    logic din_s2_r;
    logic sio_s1_r;
    logic sio_s2_r;
    spm_lstate_t lstate_r;
    spm_lstate_t lstate_nxt;
    logic [DIV_W-1:0] hcnt_r;
    logic [DIV_W-1:0] hcnt_nxt;
    logic [4:0] edge_cnt_r;
    logic [4:0] edge_cnt_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic mosi_r;
    logic mosi_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_sh_nxt;
    logic [7:0] rx_byte_nxt;
    logic done_tgl_nxt;

    wire lsb = ctrl_r[CTRL_LSB];
    wire txph = ctrl_r[CTRL_TXPH];
    wire rxph = ctrl_r[CTRL_RXPH];
    wire cpol = ctrl_r[CTRL_CPOL];
    wire half = ctrl_r[CTRL_HALF];
    wire htx = ctrl_r[CTRL_HTX];
    wire start_l = st_s2_r ^ st_s3_r;
    wire tick = (lstate_r != L_IDLE) && (hcnt_r == div_r);
    wire [4:0] edge_num = edge_cnt_r + 5'h01;
    wire [2:0] pos = edge_num[3:1];
    // phase 0 moves data after the even edges but the sixteenth, phase 1 after the odd ones
    wire tx_edge = txph ? edge_num[0] : (~edge_num[0] & (edge_num != EDGES));
    wire rx_edge = rxph ? ~edge_num[0] : edge_num[0];
    wire rx_bit = half ? sio_s2_r : din_s2_r;
    wire [7:0] rx_ins = lsb ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit};

    always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lrst_s1_r <= 1'b1;
            lrst_r <= 1'b1;
        end else begin
            lrst_s1_r <= 1'b0;
            lrst_r <= lrst_s1_r;
        end
    end

    always_ff @(posedge LINK_CLK_I or posedge lrst_r) begin
        if (lrst_r) begin
            st_s1_r <= 1'b0;
            st_s2_r <= 1'b0;
            st_s3_r <= 1'b0;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            sio_s1_r <= 1'b0;
            sio_s2_r <= 1'b0;
        end else begin
            st_s1_r <= start_tgl_r;
            st_s2_r <= st_s1_r;
            st_s3_r <= st_s2_r;
            din_s1_r <= DIN_I;
            din_s2_r <= din_s1_r;
            sio_s1_r <= DOUT_I;
            sio_s2_r <= sio_s1_r;
        end
    end

    always_comb begin
        lstate_nxt = lstate_r;
        hcnt_nxt = tick ? '0 : hcnt_r + 11'h001;
        edge_cnt_nxt = edge_cnt_r;
        sclk_nxt = sclk_r;
        mosi_nxt = mosi_r;
        oe_n_nxt = oe_n_r;
        rx_sh_nxt = rx_sh_r;
        rx_byte_nxt = rx_byte_r;
        done_tgl_nxt = done_tgl_r;
        case (lstate_r)
            L_IDLE: begin
                hcnt_nxt = '0;
                sclk_nxt = cpol;
                // shared line stays released while idle in half duplex
                oe_n_nxt = half;
                if (start_l) begin
                    lstate_nxt = L_RUN;
                    edge_cnt_nxt = 5'h00;
                    rx_sh_nxt = 8'h00;
                    oe_n_nxt = half & ~htx;
                    mosi_nxt = txph ? mosi_r : bit_at(tx_r, 3'h0, lsb);
                end
            end
            L_RUN: begin
                if (tick) begin
                    sclk_nxt = ~sclk_r;
                    edge_cnt_nxt = edge_num;
                    if (tx_edge) begin
                        mosi_nxt = bit_at(tx_r, pos, lsb);
                    end
                    if (rx_edge) begin
                        rx_sh_nxt = rx_ins;
                    end
                    if (edge_num == EDGES) begin
                        lstate_nxt = L_TAIL;
                    end
                end
            end
            L_TAIL: begin
                // a trailing half period gives the peripheral hold time
                if (tick) begin
                    lstate_nxt = L_IDLE;
                    rx_byte_nxt = rx_sh_r;
                    done_tgl_nxt = ~done_tgl_r;
                    oe_n_nxt = half;
                end
            end
            default: begin
                lstate_nxt = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge LINK_CLK_I or posedge lrst_r) begin
        if (lrst_r) begin
            lstate_r <= L_IDLE;
            hcnt_r <= '0;
            edge_cnt_r <= 5'h00;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
            oe_n_r <= 1'b0;
            rx_sh_r <= 8'h00;
            rx_byte_r <= 8'h00;
            done_tgl_r <= 1'b0;
        end else begin
            lstate_r <= lstate_nxt;
            hcnt_r <= hcnt_nxt;
            edge_cnt_r <= edge_cnt_nxt;
            sclk_r <= sclk_nxt;
            mosi_r <= mosi_nxt;
            oe_n_r <= oe_n_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_byte_r <= rx_byte_nxt;
            done_tgl_r <= done_tgl_nxt;
        end
    end

    assign SCLK_O = sclk_r;
    assign DOUT_O = mosi_r;
    assign DOUT_OE_N_O = oe_n_r;

    // ---------------- checks ----------------
    logic sclk_d_r;
    logic [DIV_W-1:0] since_r;
    always_ff @(posedge LINK_CLK_I or posedge lrst_r) begin
        if (lrst_r) begin
            sclk_d_r <= 1'b0;
            since_r <= '0;
        end else begin
            sclk_d_r <= sclk_r;
            since_r <= (sclk_r != sclk_d_r) ? '0 : since_r + 11'h001;
        end
    end

    a_msb_first: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_IDLE && start_l && !txph && !lsb) |=> mosi_r == tx_r[7])
        else $error("msb not presented first");
    a_first_early: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_IDLE && start_l && !txph) |=> mosi_r == bit_at(tx_r, 3'h0, lsb))
        else $error("first bit not shown at selection");
    a_late_hold: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_RUN && txph && edge_cnt_r == 5'h00 && !tick) |=> $stable(mosi_r))
        else $error("output moved before first edge");
    a_even_sample: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_RUN && rxph && !(tick && !edge_num[0])) |=> $stable(rx_sh_r))
        else $error("sample off an even edge");
    a_late_first: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (tick && lstate_r == L_RUN && txph && rxph && edge_cnt_r == 5'h00)
        |=> mosi_r == bit_at(tx_r, 3'h0, lsb) && $stable(rx_sh_r))
        else $error("phase 1/1 first bit wrong");
    a_half_release: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r != L_IDLE && half && !htx) |-> oe_n_r)
        else $error("shared line driven while receiving");
    a_cs_level: assert property (@(posedge CLK_I) disable iff (RST_I)
        $changed(CS_N_O) |-> $past(wr_ctrl))
        else $error("chip select moved without a write");
    a_div_range: assert property (@(posedge CLK_I) disable iff (RST_I)
        div_r >= DIV_MIN && div_r <= DIV_MAX)
        else $error("clock setting out of range");
    a_duty_equal: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (sclk_r != sclk_d_r && lstate_r != L_IDLE && edge_cnt_r >= 5'h02) |-> since_r == div_r)
        else $error("clock phases unequal");
    a_idle_low: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_IDLE && !cpol && $stable(cpol) && $past(lstate_r) == L_IDLE) |-> !sclk_r)
        else $error("clock not idle low");
    a_byte_end: assert property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        (lstate_r == L_TAIL && tick)
        |=> lstate_r == L_IDLE && sclk_r == cpol && edge_cnt_r == EDGES)
        else $error("byte did not end after sixteen edges");

    c_mode00: cover property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        lstate_r == L_TAIL && tick && !txph && !rxph);
    c_mode10: cover property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        lstate_r == L_TAIL && tick && txph && !rxph);
    c_mode11: cover property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        lstate_r == L_TAIL && tick && txph && rxph);
    c_half_rx: cover property (@(posedge LINK_CLK_I) disable iff (lrst_r)
        lstate_r == L_TAIL && tick && half && !htx);
endmodule

//--- verif/spm_peripheral.sv
// behavioural serial peripheral facing the spi master port
`timescale 1ns/1ps
module spm_peripheral (
    input wire logic sclk_i, // serial clock from the master
    input wire logic cs_n_i, // chip select, active low
    input wire logic mosi_i, // data line from the master
    input wire logic lsb_i, // bit order of this device
    input wire logic txph_i, // master transmit phase this device is set up for
    input wire logic rxph_i, // master receive phase this device is set up for
    input wire logic [7:0] resp_i, // byte sent back
    output logic so_o, // data towards the master
    output logic [7:0] rx_o, // byte taken from the master
    output logic [7:0] edges_o, // clock edges seen while selected
    output int hmin_o, // shortest half period between edges, ns
    output int hmax_o // longest half period between edges, ns
);
    real t_last;
    int dt;
    function automatic logic bit_at(input int i);
        return lsb_i ? resp_i[i] : resp_i[7 - i];
    endfunction
    initial so_o = 1'b0;
    always @(negedge cs_n_i) begin
        edges_o = 8'h00;
        rx_o = 8'h00;
        hmin_o = 32'h7fffffff;
        hmax_o = 0;
        if (!rxph_i) so_o = bit_at(0);
    end
    // once deselected the line drifts: show the inverse so a stale bit never passes
    always @(posedge cs_n_i) so_o = ~so_o;
    always @(sclk_i) begin
        if (cs_n_i === 1'b0) begin
            edges_o = edges_o + 8'h01;
            if (edges_o > 8'h01) begin
                dt = int'($realtime - t_last);
                if (dt < hmin_o) hmin_o = dt;
                if (dt > hmax_o) hmax_o = dt;
            end
            t_last = $realtime;
            // odd edges when the master sends at once, even ones when it waits
            if (edges_o[0] != txph_i) rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
            if (edges_o[0] == rxph_i && edges_o < 8'h10) so_o = bit_at(int'(edges_o >> 1));
        end
    end
endmodule

//--- verif/tb_spi_master_phase_timing.sv
// self-checking bench of the spi master port against a peripheral model
`timescale 1ns/1ps
module tb_spi_master_phase_timing;
    import spm_pkg::*;
    typedef struct packed {logic e; logic [31:0] m; logic [31:0] v;} spm_bnote_t;
    typedef struct packed {logic [7:0] m; logic [7:0] v; logic [31:0] h;} spm_lnote_t;
    logic clk = 1'b0, lclk = 1'b0, rst, psel, penable, pwrite, pready, pslverr;
    logic sclk, cs_n, dout, dout_oe_n, so, lsb, txph, rxph;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed = 32'h1f;
    logic [7:0] resp, rx, edges, tx;
    logic [6:0] c;
    logic [10:0] d;
    int hmin, hmax, error_cnt = 0, n_tests = 0;
    spm_bnote_t bq[$];
    spm_lnote_t lq[$];
    always #25 clk = ~clk;
    always #32 lclk = ~lclk;
    spm_top i_dut (.CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SCLK_O(sclk),
        .CS_N_O(cs_n), .DOUT_O(dout), .DOUT_OE_N_O(dout_oe_n),
        .DOUT_I(dout_oe_n === 1'b0 ? dout : so), .DIN_I(so));
    spm_peripheral i_per (.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(dout), .lsb_i(lsb),
        .txph_i(txph), .rxph_i(rxph), .resp_i(resp), .so_o(so), .rx_o(rx),
        .edges_o(edges), .hmin_o(hmin), .hmax_o(hmax));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string w);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask
    task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e, "bus answer");
    endtask
    task automatic chk_link(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e, "serial byte");
    endtask
    task automatic chk_pin(input logic g, input logic e);
        cmp({31'h0, g}, {31'h0, e}, "pin level");
    endtask
    // request held from setup until the edge that sees pready, released only then
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt,
        input logic [31:0] m, input logic [31:0] e, input logic err);
        bq.push_back('{err, m, e});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    task results;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && bq.size() > 0) begin
            spm_bnote_t n;
            n = bq.pop_front();
            chk_bus(prdata & n.m, n.v & n.m);
            chk_bus({31'h0, pslverr}, {31'h0, n.e});
        end
    end
    always @(posedge cs_n) begin
        if (lq.size() > 0) begin
            spm_lnote_t n;
            n = lq.pop_front();
            chk_link(32'(rx & n.m), 32'(n.v & n.m));
            chk_link(32'(edges), 32'h10);
            chk_link(hmin, n.h);
            chk_link(hmax, n.h);
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, lsb, txph, rxph} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        resp = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk_pin(cs_n, 1'b1);
        chk_pin(sclk, 1'b0);
        rdc(ADDR_CTRL, 32'hffffffff, 32'h0);
        rdc(ADDR_CLKGEN, 32'hffffffff, {21'h0, DIV_RST});
        rdc(ADDR_STATUS, 32'hffffffff, 32'h0);
        apb(1'b1, 12'h014, xs(), 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h014, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        wr(ADDR_CLKGEN, 32'hffffffff);
        rdc(ADDR_CLKGEN, 32'h7ff, {21'h0, DIV_MAX});
        // all sixteen mode mixes in full duplex, then the phase mixes on one line
        for (int m = 0; m < 24; m++) begin
            c = {2'b00, m >= 16, m[3:0]};
            c[5] = c[4] & ^m[2:0];
            d = 11'(3 + xs() % 4);
            tx = 8'(xs());
            lsb <= c[0];
            txph <= c[1];
            rxph <= c[2];
            resp <= 8'(xs());
            wr(ADDR_CLKGEN, {21'h0, d});
            wr(ADDR_CTRL, {25'h0, c});
            repeat (6) @(posedge clk);
            chk_pin(sclk, c[3]);
            chk_pin(dout_oe_n, c[4]);
            lq.push_back('{(c[4] && !c[5]) ? 8'h00 : 8'hff, tx, 32'((d + 1) * 64)});
            wr(ADDR_CTRL, {25'h0, c | 7'h40});
            // the write lands at the edge the task returns on; look once it has settled
            @(posedge clk);
            chk_pin(cs_n, 1'b0);
            wr(ADDR_TXDATA, {24'h0, tx});
            wr(ADDR_TXDATA, {24'h0, ~tx});
            wr(ADDR_CLKGEN, 32'h0);
            // mode bits are refused while busy, chip select is not
            wr(ADDR_CTRL, {25'h0, ~c | 7'h40});
            rdc(ADDR_STATUS, 32'h1, 32'h1);
            do rdc(ADDR_STATUS, 32'h0, 32'h0); while (rd[0] !== 1'b0);
            rdc(ADDR_STATUS, 32'h3, 32'h2);
            rdc(ADDR_RXDATA, (c[4] && c[5]) ? 32'h0 : 32'hff, {24'h0, resp});
            rdc(ADDR_STATUS, 32'h3, 32'h0);
            rdc(ADDR_CLKGEN, 32'h7ff, {21'h0, d});
            rdc(ADDR_CTRL, 32'h7f, {25'h0, c | 7'h40});
            chk_pin(sclk, c[3]);
            chk_pin(cs_n, 1'b0);
            chk_pin(dout_oe_n, c[4]);
            wr(ADDR_CTRL, {25'h0, c});
        end
        repeat (4) @(posedge clk);
        results();
    end
endmodule
